//--- rtl/bd_ownership.sv
/*
  buffer descriptor ownership engine: token decode against the descriptor
  status byte, buffer address stepping, toggle check, handshake choice,
  write-back of status and count, status fifo push and event pulses.
  assumes token, packet and enable inputs come from logic on ref_clk_i;
  a new token is offered only in idle, at least one cycle after the last.
*/
// Design decisions made here: the plain strobed port and the address map.
`include "bd_consts.svh"

module bd_ownership (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // core register port
  input wire logic [7:0] core_addr_i,
  input wire logic [7:0] core_wdata_i,
  input wire logic core_wr_i,
  input wire logic core_rd_i,
  output logic [7:0] core_rdata_o,
  // endpoint control
  input wire logic [15:0] endpoint_enable_i,
  // serial interface engine side
  input wire bd_pkg::token_type token_i,
  input wire bd_pkg::packet_type packet_i,
  output bd_pkg::handshake_type handshake_o,
  output bd_pkg::buf_access_type buf_o,
  // events
  output bd_pkg::fifo_entry_type transfer_status_fifo_o,
  output logic transaction_done_flag_o,
  output bd_pkg::halt_event_type endpoint_halt_flag_o,
  output logic stall_irq_o
);
  import bd_pkg::*;

  typedef struct packed {
    phase_type phase;
    logic [5:0] desc;
    logic [3:0] pid;
    logic dir_in;
    logic [15:0] addr;
    logic [9:0] count;
    logic keep_owned;
    logic addr_step_off;
    logic toggle_check_on;
    logic expected_toggle;
    logic odd;
    logic tog_bad;
    handshake_type hs;
    buf_access_type buf_acc;
    fifo_entry_type fifo;
    logic done;
    halt_event_type halt;
    logic stall_irq;
  } engine_state_type;

  engine_state_type s;
  engine_state_type next_s;
  desc_type eng_desc;
  logic [5:0] eng_idx;
  logic st_we;
  logic cnt_we;
  logic [7:0] st_wd;
  logic [7:0] cnt_wd;

  // descriptor n belongs to endpoint n/4
  function automatic logic [3:0] ep_of(input logic [5:0] d);
    ep_of = d[5:2];
  endfunction

  assign eng_idx = (s.phase == PH_IDLE) ? token_i.desc : s.desc;

  desc_table u_table (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .core_addr_i(core_addr_i),
    .core_wdata_i(core_wdata_i),
    .core_wr_i(core_wr_i),
    .core_rd_i(core_rd_i),
    .core_rdata_o(core_rdata_o),
    .eng_idx_i(eng_idx),
    .eng_status_we_i(st_we),
    .eng_status_i(st_wd),
    .eng_count_we_i(cnt_we),
    .eng_count_i(cnt_wd),
    .eng_desc_o(eng_desc)
  );

  always_comb begin
    logic tog_bad_now;
    logic odd_now;
    logic [9:0] cnt_now;
    tog_bad_now = s.tog_bad;
    odd_now = s.odd;
    cnt_now = s.count;
    next_s = s;
    next_s.hs.valid = 1'b0;
    next_s.buf_acc.valid = 1'b0;
    next_s.fifo.valid = 1'b0;
    next_s.done = 1'b0;
    next_s.halt.valid = 1'b0;
    next_s.stall_irq = 1'b0;
    st_we = 1'b0;
    cnt_we = 1'b0;
    st_wd = 8'h00;
    cnt_wd = 8'h00;
    case (s.phase)
      PH_IDLE: begin
        // disabled endpoints: no answer, bytes stay plain ram
        if (token_i.valid && endpoint_enable_i[ep_of(token_i.desc)]) begin
          if (!eng_desc.status[`ST_ENGINE_OWNS]) begin
            next_s.hs.valid = 1'b1;
            next_s.hs.code = HS_NAK;
          end else if (eng_desc.status[`ST_BUFFER_HALT] && token_i.pid != `PID_SETUP) begin
            // descriptor left untouched, ownership kept
            next_s.hs.valid = 1'b1;
            next_s.hs.code = HS_STALL;
            next_s.halt.valid = 1'b1;
            next_s.halt.ep = ep_of(token_i.desc);
            next_s.stall_irq = 1'b1;
          end else begin
            // setup on a halted descriptor runs as a normal transaction
            next_s.phase = PH_DATA;
            next_s.desc = token_i.desc;
            next_s.pid = token_i.pid;
            next_s.dir_in = (token_i.pid == `PID_IN);
            next_s.addr = {eng_desc.addr_hi, eng_desc.addr_lo};
            next_s.count = 10'h000;
            // core layout of the status byte
            next_s.keep_owned = eng_desc.status[`ST_KEEP_OWNED];
            next_s.addr_step_off = eng_desc.status[`ST_ADDR_STEP_OFF];
            next_s.toggle_check_on = eng_desc.status[`ST_TOGGLE_CHECK_ON];
            next_s.expected_toggle = eng_desc.status[`ST_EXPECTED_TOGGLE];
            next_s.odd = 1'b0;
            next_s.tog_bad = 1'b0;
          end
        end
      end
      PH_DATA: begin
        if (packet_i.start) begin
          odd_now = packet_i.odd;
          tog_bad_now = s.toggle_check_on && !s.dir_in && (packet_i.odd != s.expected_toggle);
        end
        next_s.odd = odd_now;
        next_s.tog_bad = tog_bad_now;
        if (packet_i.byte_valid) begin
          // wrong-toggle data never reaches the buffer
          next_s.buf_acc.valid = !tog_bad_now;
          next_s.buf_acc.write = !s.dir_in;
          next_s.buf_acc.addr = s.addr;
          next_s.buf_acc.data = packet_i.data;
          cnt_now = s.count + 10'h001;
          if (!s.addr_step_off) begin
            next_s.addr = s.addr + 16'h0001;
          end
        end
        next_s.count = cnt_now;
        if (packet_i.last) begin
          next_s.phase = PH_IDLE;
          if (packet_i.err) begin
            // ownership and status byte untouched
            next_s.hs.valid = !s.dir_in;
            next_s.hs.code = HS_NAK;
          end else if (tog_bad_now) begin
            next_s.hs.valid = 1'b1;
            next_s.hs.code = HS_ACK;
          end else begin
            next_s.hs.valid = !s.dir_in;
            next_s.hs.code = HS_ACK;
            // engine layout: own, toggle seen, pid, count high bits
            st_we = 1'b1;
            st_wd = {s.keep_owned, odd_now, s.pid, cnt_now[9:8]};
            cnt_we = 1'b1;
            cnt_wd = cnt_now[7:0];
            next_s.fifo.valid = !s.keep_owned;
            next_s.fifo.desc = s.desc;
            next_s.fifo.dir_in = s.dir_in;
            next_s.done = !s.keep_owned;
          end
        end
      end
      default: begin
        next_s.phase = PH_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign handshake_o = s.hs;
  assign buf_o = s.buf_acc;
  assign transfer_status_fifo_o = s.fifo;
  assign transaction_done_flag_o = s.done;
  assign endpoint_halt_flag_o = s.halt;
  assign stall_irq_o = s.stall_irq;

endmodule // bd_ownership

//--- rtl/bd_consts.svh
/*
  constants for the buffer descriptor ownership block: descriptor layout,
  status bit positions, token pids, table geometry.
  assumes it is included once per compile unit by its bare name.

  // Function
  // - status bit 7 marks engine ownership
  // - status byte has core and engine layouts
  // - status byte readable anytime by both
  // - engine writes token pid and count back
  // - completion clears ownership unless keep/halt
  // - core accesses never blocked while engine owns
  // - keep_owned holds ownership, suppresses fifo/flag
  // - addr_step_off freezes the buffer address
  // - toggle_check_on compares data parity with bit 6
  // - wrong toggle dropped, still answered ACK
  // - errored OUT packet gets NAK, nothing changes
  // - buffer_halt answers tokens with STALL
  // - STALL sets endpoint halt flag and interrupt
  // - halt keeps descriptor; SETUP clears and releases
  // - ten-bit count, high bits in status 1:0
  // - four bytes per descriptor, 64 descriptors
  // - disabled endpoint descriptors are plain RAM
*/
`ifndef BD_CONSTS_SVH
`define BD_CONSTS_SVH

`define BD_COUNT 64
`define BD_TABLE_BYTES 256
`define BD_OFS_STATUS 2'h0
`define BD_OFS_COUNT 2'h1
`define BD_OFS_ADDR_LO 2'h2
`define BD_OFS_ADDR_HI 2'h3

`define ST_ENGINE_OWNS 7
`define ST_EXPECTED_TOGGLE 6
`define ST_KEEP_OWNED 5
`define ST_ADDR_STEP_OFF 4
`define ST_TOGGLE_CHECK_ON 3
`define ST_BUFFER_HALT 2
`define ST_PID_HI 5
`define ST_PID_LO 2
`define ST_COUNT_HI 1
`define ST_COUNT_LO 0

`define PID_OUT 4'h1
`define PID_IN 4'h9
`define PID_SETUP 4'hd

`endif

//--- rtl/bd_pkg.sv
/*
  types shared by the descriptor table and the ownership engine.
  assumes bd_consts.svh defines nothing that clashes with these names.
*/
package bd_pkg;

  typedef enum logic [1:0] {HS_ACK, HS_NAK, HS_STALL} hs_code_type;
  typedef enum logic {PH_IDLE, PH_DATA} phase_type;

  typedef struct packed {
    logic valid;
    hs_code_type code;
  } handshake_type;

  typedef struct packed {
    logic valid;
    logic [5:0] desc;
    logic [3:0] pid;
  } token_type;

  typedef struct packed {
    logic start;
    logic odd;
    logic byte_valid;
    logic [7:0] data;
    logic last;
    logic err;
  } packet_type;

  typedef struct packed {
    logic valid;
    logic write;
    logic [15:0] addr;
    logic [7:0] data;
  } buf_access_type;

  typedef struct packed {
    logic valid;
    logic [5:0] desc;
    logic dir_in;
  } fifo_entry_type;

  typedef struct packed {
    logic valid;
    logic [3:0] ep;
  } halt_event_type;

  typedef struct packed {
    logic [7:0] addr_hi;
    logic [7:0] addr_lo;
    logic [7:0] count;
    logic [7:0] status;
  } desc_type;

  typedef struct packed {
    logic [255:0][7:0] mem;
    logic [7:0] rdata;
  } table_state_type;

endpackage

//--- rtl/desc_table.sv
/*
  descriptor table: 64 descriptors of four bytes, core port with registered
  read, engine port with combinational read of one whole descriptor.
  assumes one clock; engine writes win over a core write to the same byte.
*/
`include "bd_consts.svh"

module desc_table (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // core port
  input wire logic [7:0] core_addr_i,
  input wire logic [7:0] core_wdata_i,
  input wire logic core_wr_i,
  input wire logic core_rd_i,
  output logic [7:0] core_rdata_o,
  // engine port
  input wire logic [5:0] eng_idx_i,
  input wire logic eng_status_we_i,
  input wire logic [7:0] eng_status_i,
  input wire logic eng_count_we_i,
  input wire logic [7:0] eng_count_i,
  output bd_pkg::desc_type eng_desc_o
);
  import bd_pkg::*;

  table_state_type s;
  table_state_type next_s;

  always_comb begin
    next_s = s;
    // no blocking of core access while engine owns
    if (core_wr_i) begin
      next_s.mem[core_addr_i] = core_wdata_i;
    end
    if (core_rd_i) begin
      next_s.rdata = s.mem[core_addr_i];
    end
    if (eng_status_we_i) begin
      next_s.mem[{eng_idx_i, `BD_OFS_STATUS}] = eng_status_i;
    end
    if (eng_count_we_i) begin
      next_s.mem[{eng_idx_i, `BD_OFS_COUNT}] = eng_count_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign core_rdata_o = s.rdata;
  // four consecutive bytes per descriptor
  assign eng_desc_o = {s.mem[{eng_idx_i, `BD_OFS_ADDR_HI}], s.mem[{eng_idx_i, `BD_OFS_ADDR_LO}],
                       s.mem[{eng_idx_i, `BD_OFS_COUNT}], s.mem[{eng_idx_i, `BD_OFS_STATUS}]};

endmodule // desc_table

//--- test/bd_ownership_assertions.sv
/* port checker for bd_ownership.
   assumes one clock and the bind below. */
module bd_ownership_assertions (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // watched ports
  input wire logic [15:0] endpoint_enable_i,
  input wire bd_pkg::token_type token_i,
  input wire bd_pkg::packet_type packet_i,
  input wire bd_pkg::handshake_type handshake_o,
  input wire bd_pkg::buf_access_type buf_o,
  input wire bd_pkg::fifo_entry_type transfer_status_fifo_o,
  input wire logic transaction_done_flag_o,
  input wire bd_pkg::halt_event_type endpoint_halt_flag_o,
  input wire logic stall_irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import bd_pkg::*;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  logic stall;
  logic ack;
  assign stall = handshake_o.valid && handshake_o.code == HS_STALL;
  assign ack = handshake_o.valid && handshake_o.code == HS_ACK;
  property p_halt_irq; endpoint_halt_flag_o.valid |-> stall_irq_o; endproperty
  a_halt_irq: assert property (p_halt_irq) else $error("halt without irq");
  property p_stall_halt;
    stall |-> endpoint_halt_flag_o.valid && endpoint_halt_flag_o.ep == $past(token_i.desc[5:2]);
  endproperty
  a_stall_halt: assert property (p_stall_halt) else $error("stall without halt");
  property p_stall_token; stall |-> $past(token_i.valid); endproperty
  a_stall_token: assert property (p_stall_token) else $error("stall without token");
  property p_buf_byte; buf_o.valid |-> $past(packet_i.byte_valid); endproperty
  a_buf_byte: assert property (p_buf_byte) else $error("buffer access without byte");
  property p_addr_step; buf_o.valid && $past(buf_o.valid) |-> buf_o.addr - $past(buf_o.addr) <= 16'h1; endproperty
  a_addr_step: assert property (p_addr_step) else $error("address jump");
  property p_disabled; token_i.valid && !endpoint_enable_i[token_i.desc[5:2]] |=> !handshake_o.valid; endproperty
  a_disabled: assert property (p_disabled) else $error("disabled endpoint answered");
  property p_err_nak; packet_i.last && packet_i.err |=> !transaction_done_flag_o && !ack; endproperty
  a_err_nak: assert property (p_err_nak) else $error("errored packet accepted");
  property p_done_fifo; transaction_done_flag_o |-> transfer_status_fifo_o.valid; endproperty
  a_done_fifo: assert property (p_done_fifo) else $error("done without fifo push");
  c_stall: cover property (stall);
  c_done: cover property (transaction_done_flag_o);
  c_nak: cover property (handshake_o.valid && handshake_o.code == HS_NAK);
endmodule // bd_ownership_assertions
bind bd_ownership bd_ownership_assertions chk (.ref_clk_i, .resetn_i, .endpoint_enable_i, .token_i, .packet_i,
  .handshake_o, .buf_o, .transfer_status_fifo_o, .transaction_done_flag_o, .endpoint_halt_flag_o, .stall_irq_o);

//--- test/usb_host_model.sv
/* host side model: tokens and data packets, records answers.
   assumes send is called right after a rising edge. */
module usb_host_model (
  // clock
  input wire logic ref_clk_i,
  // engine side
  output bd_pkg::token_type token_o,
  output bd_pkg::packet_type packet_o,
  input wire bd_pkg::handshake_type handshake_i,
  input wire bd_pkg::buf_access_type buf_i,
  input wire logic done_i
);
  timeunit 1ns;
  timeprecision 1ps;
  import bd_pkg::*;
  int hs_cnt = 0;
  int done_cnt = 0;
  logic [1:0] hs_code = 2'h0;
  logic [15:0] last_addr = 16'h0;
  logic [7:0] last_data = 8'h0;
  logic last_write = 1'b0;
  initial token_o = '0;
  initial packet_o = '0;
  always @(posedge ref_clk_i) begin
    if (handshake_i.valid) hs_cnt++;
    if (handshake_i.valid) hs_code = handshake_i.code;
    if (done_i) done_cnt++;
    if (buf_i.valid) last_addr = buf_i.addr;
    if (buf_i.valid) last_data = buf_i.data;
    if (buf_i.valid) last_write = buf_i.write;
  end
  task automatic send(input logic [5:0] d, input logic [3:0] pid, input int n, input logic odd, input logic err);
    hs_cnt = 0;
    done_cnt = 0;
    hs_code = 2'h0;
    // marker that no buffer access reached the model
    last_addr = 16'hffff;
    token_o <= '{1'b1, d, pid};
    @(posedge ref_clk_i);
    // released lines show the inverse of the last value
    token_o <= '{1'b0, ~d, ~pid};
    for (int i = 0; i < n; i++) begin
      packet_o <= '{i == 0, odd, 1'b1, 8'(i) ^ 8'h5a, i == n - 1, err && i == n - 1};
      @(posedge ref_clk_i);
    end
    packet_o <= '{1'b0, ~odd, 1'b0, 8'(n) ^ 8'ha5, 1'b0, 1'b0};
    repeat (3) @(posedge ref_clk_i);
  endtask
endmodule // usb_host_model

//--- test/test_bd_ownership.sv
/* bench for bd_ownership: core bus tasks, host model, checks.
   assumes design, checker and host model compiled first. */
`include "bd_consts.svh"
module test_bd_ownership;
  timeunit 1ns;
  timeprecision 1ps;
  import bd_pkg::*;
  logic ref_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic core_wr_i = 1'b0;
  logic core_rd_i = 1'b0;
  logic [7:0] core_addr_i = 8'h0;
  logic [7:0] core_wdata_i = 8'h0;
  logic [7:0] core_rdata_o;
  logic [15:0] endpoint_enable_i = 16'h0;
  token_type token_i;
  packet_type packet_i;
  handshake_type handshake_o;
  buf_access_type buf_o;
  fifo_entry_type transfer_status_fifo_o;
  logic transaction_done_flag_o;
  halt_event_type endpoint_halt_flag_o;
  logic stall_irq_o;
  int num_errors = 0;
  int checks = 0;
  int cycles = 0;
  int seed = 20;
  int n = 0;
  logic [5:0] d = 6'h0;
  logic odd = 1'b0;
  logic [7:0] v;
  logic [6:0] fifo_seen = 7'h0;
  logic [4:0] halt_seen = 5'h0;
  always #10 ref_clk_i = ~ref_clk_i;
  bd_ownership dut (.ref_clk_i, .resetn_i, .core_addr_i, .core_wdata_i, .core_wr_i, .core_rd_i, .core_rdata_o,
    .endpoint_enable_i, .token_i, .packet_i, .handshake_o, .buf_o, .transfer_status_fifo_o,
    .transaction_done_flag_o, .endpoint_halt_flag_o, .stall_irq_o);
  usb_host_model host (.ref_clk_i, .token_o(token_i), .packet_o(packet_i), .handshake_i(handshake_o),
    .buf_i(buf_o), .done_i(transaction_done_flag_o));
  task automatic finish_test();
    if (num_errors == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] wd);
    core_wr_i <= w;
    core_rd_i <= !w;
    core_addr_i <= a;
    core_wdata_i <= wd;
    @(posedge ref_clk_i);
    core_wr_i <= 1'b0;
    core_rd_i <= 1'b0;
    @(negedge ref_clk_i);
    v = core_rdata_o;
    @(posedge ref_clk_i);
  endtask
  task automatic run(input logic [7:0] st, input logic [3:0] pid, input int cnt, input logic err);
    bus(1'b1, {d, 2'h1}, 8'h40);
    bus(1'b1, {d, 2'h2}, 8'h00);
    bus(1'b1, {d, 2'h3}, 8'h05);
    bus(1'b1, {d, 2'h0}, st);
    host.send(d, pid, cnt, odd, err);
    bus(1'b0, {d, 2'h0}, 8'h0);
  endtask
  task automatic hs_is(input logic [3:0] c, input logic [1:0] code);
    check("handshake", 16'({host.hs_cnt[3:0], host.hs_code}), 16'({c, code}));
  endtask
  function automatic logic [7:0] wb(input logic keep, input logic [3:0] pid);
    return {keep, odd, pid, 2'(n >> 8)};
  endfunction
  // last status fifo push and last halt event, with the irq beside it
  always @(posedge ref_clk_i) begin
    if (transfer_status_fifo_o.valid) fifo_seen <= {transfer_status_fifo_o.desc, transfer_status_fifo_o.dir_in};
    if (endpoint_halt_flag_o.valid) halt_seen <= {stall_irq_o, endpoint_halt_flag_o.ep};
  end
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      finish_test();
    end
  end
  initial begin
    repeat (20) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    d = 6'($random(seed));
    endpoint_enable_i <= ~(16'h1 << (d[5:2] + 4'h1));
    run(8'h00, `PID_OUT, 0, 1'b0);
    hs_is(4'h1, HS_NAK);
    check("unowned status", v, 8'h00);
    n = 1 + ($random(seed) & 32'h1ff);
    odd = 1'($random(seed));
    run(8'h80, `PID_OUT, n, 1'b0);
    hs_is(4'h1, HS_ACK);
    check("status", v, wb(1'b0, `PID_OUT));
    check("done", 16'(host.done_cnt), 16'h1);
    check("last addr", host.last_addr, 16'(16'h0500 + n - 1));
    check("last data", 16'(host.last_data), 16'(8'(n - 1) ^ 8'h5a));
    check("fifo", 16'(fifo_seen), 16'({d, 1'b0}));
    bus(1'b0, {d, 2'h1}, 8'h0);
    check("count", v, n[7:0]);
    n = 257;
    run(8'hb0, `PID_OUT, n, 1'b0);
    check("keep status", v, wb(1'b1, `PID_OUT));
    check("keep done", 16'(host.done_cnt), 16'h0);
    check("fixed addr", host.last_addr, 16'h0500);
    bus(1'b1, {d, 2'h1}, 8'h33);
    bus(1'b0, {d, 2'h1}, 8'h0);
    check("owned write", v, 8'h33);
    odd = 1'b1;
    n = 3;
    run(8'h88, `PID_OUT, n, 1'b0);
    hs_is(4'h1, HS_ACK);
    check("toggle status", v, 8'h88);
    check("dropped", host.last_addr, 16'hffff);
    check("dropped done", 16'(host.done_cnt), 16'h0);
    run(8'h80, `PID_OUT, n, 1'b1);
    hs_is(4'h1, HS_NAK);
    check("error status", v, 8'h80);
    run(8'h84, `PID_OUT, 0, 1'b0);
    hs_is(4'h1, HS_STALL);
    check("halt status", v, 8'h84);
    check("halt flag", 16'(halt_seen), 16'({1'b1, d[5:2]}));
    odd = 1'b0;
    host.send(d, `PID_SETUP, n, odd, 1'b0);
    bus(1'b0, {d, 2'h0}, 8'h0);
    check("setup status", v, wb(1'b0, `PID_SETUP));
    n = 2;
    run(8'h80, `PID_IN, n, 1'b0);
    hs_is(4'h0, HS_ACK);
    check("in status", v, wb(1'b0, `PID_IN));
    check("in done", 16'(host.done_cnt), 16'h1);
    check("in fifo", 16'(fifo_seen), 16'({d, 1'b1}));
    check("in read", 16'(host.last_write), 16'h0);
    check("in addr", host.last_addr, 16'h0501);
    d = {d[5:2] + 4'h1, d[1:0]};
    run(8'h80, `PID_OUT, 0, 1'b0);
    hs_is(4'h0, HS_ACK);
    finish_test();
  end
endmodule // test_bd_ownership
